// >>> common/rvms_pkg.sv
// Constants, state codes and the register map of the reset and voltage
// monitor sequencer.
// Assumes one 250 MHz bus clock and a slow tick sampled as a plain input.
package rvms_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map: indices, byte address is four times the index
	localparam int               ADDR_W      = 10;
	localparam logic [7:0]       IDX_STATUS  = 8'hE0;
	localparam logic [7:0]       IDX_TRIM    = 8'hE1;
	localparam logic [7:0]       IDX_VMCTRL  = 8'hE3;
	localparam logic [7:0]       IDX_VMCMP   = 8'hE4;

	// Reset values
	localparam logic [7:0]       VMCTRL_RST  = 8'h00;
	localparam logic [7:0]       VMCMP_RST   = 8'h00;
	localparam logic [7:0]       TRIM_RST    = 8'h00;

	// Field positions
	localparam int               TRIP_LSB    = 4;
	localparam int               THROTTLE_B  = 3;
	localparam int               THRESH_LSB  = 0;
	localparam int               LVD_B       = 1;
	localparam int               PON_B       = 4;
	localparam int               WDRF_B      = 5;
	localparam int               RAMLIM_B    = 0;

	// Slow-tick counts from end of a source to processor release
	localparam logic [9:0]       REL_IMPRECISE_SUPPLY_RESET    = 10'h200;
	localparam logic [9:0]       REL_PRECISE_SUPPLY_RESET    = 10'h001;
	localparam logic [9:0]       REL_EXTERNAL_RESET_PIN    = 10'h008;
	localparam logic [9:0]       REL_WDR     = 10'h001;

	// Low-power window of the main oscillator, in slow ticks
	localparam int               TICK_PERIOD_NS = 31250;
	localparam int               LP_WINDOW_US   = 64000;
	localparam int               LP_TICKS_I     =
		(LP_WINDOW_US * 1000) / TICK_PERIOD_NS;
	localparam logic [11:0]      LP_TICKS    = 12'(LP_TICKS_I);

	// Bus responses
	localparam logic [1:0]       RESP_OKAY   = 2'h0;
	localparam logic [1:0]       RESP_SLVERR = 2'h2;

	typedef enum logic [5:0]
	{
		ST_RUN    = 6'h01,
		ST_HOLD   = 6'h02,
		ST_EXTEND = 6'h04,
		ST_WDOG   = 6'h08,
		ST_COUNT  = 6'h10,
		ST_SYNC   = 6'h20
	} rvms_state_type;

	typedef enum logic [1:0]
	{
		SRC_IMPRECISE_SUPPLY_RESET = 2'h0,
		SRC_PRECISE_SUPPLY_RESET = 2'h1,
		SRC_EXTERNAL_RESET_PIN = 2'h2,
		SRC_WDR  = 2'h3
	} rvms_src_type;

	// Release count belonging to each reset source
	function automatic logic [9:0] rvms_rel_ticks(input rvms_src_type k);
		case (k)
			SRC_IMPRECISE_SUPPLY_RESET: return REL_IMPRECISE_SUPPLY_RESET;
			SRC_PRECISE_SUPPLY_RESET: return REL_PRECISE_SUPPLY_RESET;
			SRC_EXTERNAL_RESET_PIN: return REL_EXTERNAL_RESET_PIN;
			default:  return REL_WDR;
		endcase
	endfunction

endpackage

// >>> logic/rvms_top.sv
// Reset sequencer and voltage monitor registers behind an AXI4-Lite slave.
// Assumes all inputs synchronous to aclk; the slow tick is a level input
// whose rising edges are counted, and it may stop while its oscillator is
// powered down.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns

module rvms_top
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       imprecise_supply_reset,
	input  wire logic                       precise_supply_reset,
	input  wire logic                       external_reset_pin,
	input  wire logic                       watchdog_reset_event,
	input  wire logic                       low_voltage_detect,
	input  wire logic                       slow_tick_clock,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [rvms_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [rvms_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            internal_reset,
	output logic                            main_osc_power_down,
	output logic                            slow_osc_power_down,
	output logic                            bandgap_power_on,
	output logic                            throttle_speed_reset,
	output logic                            low_voltage_irq,
	output logic [1:0]                      supply_trip_level,
	output logic                            throttle_on_low_voltage,
	output logic [2:0]                      low_voltage_threshold,
	output logic                            power_on_flag,
	output logic                            ram_init_limit
);
	import rvms_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Whole state of the block in one record
	typedef struct packed
	{
		rvms_state_type        state;
		rvms_src_type          kind;
		logic                  tick_prev;
		logic [9:0]            cnt;
		logic [11:0]           lp_cnt;
		logic                  wd_phase;
		logic [7:0]            vmctrl;
		logic [7:0]            trim;
		logic                  pon;
		logic                  wdrf;
		logic                  ramlim;
		logic                  cmp_lvd;
		logic                  aw_have;
		logic [ADDR_W-1:0]     aw_addr;
		logic                  w_have;
		logic [7:0]            wdata;
		logic                  wstb;
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [7:0]            rdata;
		logic                  cpu_reset;
		logic                  mosc_off;
		logic                  sosc_off;
		logic                  bgap_on;
		logic                  throttle;
		logic                  irq;
		logic [1:0]            osc_ticks;
		logic [9:0]            hlp_ticks;
	} rvms_regs_type;

	rvms_regs_type s_q;
	rvms_regs_type s_d;

	logic          tick;
	logic          sup_src;
	rvms_src_type  sup_kind;
	logic [7:0]    ar_idx;
	logic          ar_ok;
	logic [7:0]    aw_idx;
	logic          aw_ok;

	////////////////////////////////////////////////////////////////////////
	// Slow tick edge and source decode
	assign tick    = slow_tick_clock && !s_q.tick_prev;
	assign sup_src = imprecise_supply_reset || precise_supply_reset
		|| external_reset_pin;
	// Imprecise supply outranks the pin, the pin outranks precise supply
	assign sup_kind = imprecise_supply_reset ? SRC_IMPRECISE_SUPPLY_RESET
		: (external_reset_pin ? SRC_EXTERNAL_RESET_PIN : SRC_PRECISE_SUPPLY_RESET);
	assign ar_idx  = s_axi_araddr[ADDR_W-1:2];
	assign ar_ok   = (s_axi_araddr[1:0] == 2'h0) && ((ar_idx == IDX_STATUS)
		|| (ar_idx == IDX_TRIM) || (ar_idx == IDX_VMCTRL)
		|| (ar_idx == IDX_VMCMP));
	assign aw_idx  = s_q.aw_addr[ADDR_W-1:2];
	assign aw_ok   = (s_q.aw_addr[1:0] == 2'h0) && ((aw_idx == IDX_STATUS)
		|| (aw_idx == IDX_TRIM) || (aw_idx == IDX_VMCTRL)
		|| (aw_idx == IDX_VMCMP));

	////////////////////////////////////////////////////////////////////////
	// Next state: bus slave first, sequencer overrides it afterwards
	always_comb
	begin
		s_d           = s_q;
		s_d.tick_prev = slow_tick_clock;
		s_d.cmp_lvd   = low_voltage_detect;

		// Address and data are taken in either order
		if (s_axi_awvalid && s_q.awready)
		begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready)
		begin
			s_d.w_have = 1'b1;
			s_d.wdata  = s_axi_wdata[7:0];
			s_d.wstb   = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;

		// Write commits once both halves are held
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = aw_ok ? RESP_OKAY : RESP_SLVERR;
			if (aw_ok && s_q.wstb)
			begin
				case (aw_idx)
					IDX_STATUS:
					begin
						// Power-on and watchdog flags clear on a written zero, never set; ramlim takes the bit
						if (!s_q.wdata[PON_B])
							s_d.pon = 1'b0;
						if (!s_q.wdata[WDRF_B])
							s_d.wdrf = 1'b0;
						s_d.ramlim = s_q.wdata[RAMLIM_B];
					end
					IDX_TRIM:   s_d.trim = s_q.wdata;
					// Reserved bits are not stored at all
					IDX_VMCTRL: s_d.vmctrl = s_q.wdata & 8'h3F;
					default:    s_d.vmctrl = s_d.vmctrl;
				endcase
			end
		end

		// Read answers one cycle after the address is taken
		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_q.arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = ar_ok ? RESP_OKAY : RESP_SLVERR;
			s_d.rdata  = 8'h00;
			if (ar_ok)
			begin
				case (ar_idx)
					IDX_STATUS:
					begin
						s_d.rdata[PON_B]    = s_q.pon;
						s_d.rdata[WDRF_B]   = s_q.wdrf;
						s_d.rdata[RAMLIM_B] = s_q.ramlim;
					end
					IDX_TRIM:   s_d.rdata = s_q.trim;
					IDX_VMCTRL: s_d.rdata = s_q.vmctrl;
					IDX_VMCMP:  s_d.rdata[LVD_B] = s_q.cmp_lvd;
					default:    s_d.rdata = 8'h00;
				endcase
			end
		end

		// Low-power window runs from a supply or pin reset that leaves run, holding at LP_TICKS
		if (tick && (s_q.lp_cnt != LP_TICKS))
			s_d.lp_cnt = s_q.lp_cnt + 12'h001;

		// Sequencer; supply and pin sources win over the watchdog
		case (s_q.state)
			ST_RUN, ST_COUNT, ST_SYNC, ST_EXTEND, ST_WDOG:
			begin
				if (sup_src)
				begin
					s_d.state = ST_HOLD;
					// Kind known on entry: no stale watchdog kind
					// leaves the oscillator running in the first cycle
					s_d.kind  = sup_kind;
					if (s_q.state == ST_RUN)
						s_d.lp_cnt = 12'h000;
				end
				else if (watchdog_reset_event && (s_q.state != ST_WDOG)
					&& (s_q.state != ST_EXTEND))
				begin
					s_d.state    = ST_WDOG;
					s_d.wd_phase = 1'b0;
				end
				else if (s_q.state == ST_RUN)
					s_d.state = ST_RUN;
				else if (s_q.state == ST_SYNC)
					s_d.state = ST_RUN;
				else if (s_q.state == ST_EXTEND)
				begin
					// Precise supply reset stretched to the next tick
					if (tick)
					begin
						s_d.state = ST_COUNT;
						s_d.cnt   = REL_PRECISE_SUPPLY_RESET;
					end
				end
				else if (s_q.state == ST_WDOG)
				begin
					// First tick aligns, second ends one full period
					if (tick)
					begin
						s_d.wd_phase = 1'b1;
						if (s_q.wd_phase)
						begin
							s_d.state = ST_COUNT;
							s_d.cnt   = REL_WDR;
						end
					end
				end
				else if (tick)
				begin
					// Counting straight on: no low-power wait
					if (s_q.cnt == 10'h001)
						s_d.state = ST_SYNC;
					else
						s_d.cnt = s_q.cnt - 10'h001;
				end
			end
			ST_HOLD:
			begin
				if (sup_src)
				begin
					// The most demanding source still active is remembered
					s_d.kind = sup_kind;
				end
				else if (s_q.kind == SRC_PRECISE_SUPPLY_RESET)
					s_d.state = ST_EXTEND;
				else
				begin
					s_d.state = ST_COUNT;
					s_d.cnt   = rvms_rel_ticks(s_q.kind);
				end
			end
			default:
			begin
				s_d.state = ST_HOLD;
				s_d.kind  = SRC_IMPRECISE_SUPPLY_RESET;
			end
		endcase

		// Register clearing and status update during reset
		if (s_d.state == ST_WDOG)
			s_d.kind = SRC_WDR;
		if ((s_d.state == ST_HOLD) || (s_d.state == ST_WDOG))
		begin
			s_d.vmctrl = VMCTRL_RST;
			if (s_d.kind != SRC_PRECISE_SUPPLY_RESET)
				s_d.trim = TRIM_RST;
			if (s_d.kind == SRC_WDR)
			begin
				s_d.pon  = 1'b0;
				s_d.wdrf = 1'b1;
			end
			else
			begin
				s_d.pon    = 1'b1;
				s_d.wdrf   = 1'b0;
				s_d.ramlim = 1'b0;
			end
		end

		// Reset and main oscillator controls follow the state being entered
		s_d.cpu_reset = (s_d.state != ST_RUN);
		s_d.sosc_off  = imprecise_supply_reset;
		s_d.bgap_on   = 1'b1;
		// Main oscillator comes back for the last tick at the latest
		s_d.mosc_off  = (s_d.kind != SRC_WDR) && ((s_d.state == ST_HOLD)
			|| (s_d.state == ST_EXTEND) || ((s_d.state == ST_COUNT)
			&& (s_d.lp_cnt != LP_TICKS) && (s_d.cnt != 10'h001)));
		s_d.throttle  = s_d.vmctrl[THROTTLE_B] && low_voltage_detect;
		s_d.irq       = low_voltage_detect;

		// Bus readiness never overlaps a held item or a pending answer
		s_d.awready = !s_d.aw_have && !s_d.bvalid;
		s_d.wready  = !s_d.w_have && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;

		// Checking aids: ticks with oscillator on, ticks counted
		if (s_q.mosc_off)
			s_d.osc_ticks = 2'h0;
		else if (tick && (s_q.osc_ticks != 2'h3))
			s_d.osc_ticks = s_q.osc_ticks + 2'h1;
		if (s_q.state != ST_COUNT)
			s_d.hlp_ticks = 10'h000;
		else if (tick)
			s_d.hlp_ticks = s_q.hlp_ticks + 10'h001;
	end

	////////////////////////////////////////////////////////////////////////
	// State register; bus reset behaves as a fresh power-up
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q.state     <= ST_HOLD;
			s_q.kind      <= SRC_IMPRECISE_SUPPLY_RESET;
			s_q.tick_prev <= 1'b0;
			s_q.cnt       <= 10'h000;
			s_q.lp_cnt    <= 12'h000;
			s_q.wd_phase  <= 1'b0;
			s_q.vmctrl    <= VMCTRL_RST;
			s_q.trim      <= TRIM_RST;
			s_q.pon       <= 1'b1;
			s_q.wdrf      <= 1'b0;
			s_q.ramlim    <= 1'b0;
			s_q.cmp_lvd   <= 1'b0;
			s_q.aw_have   <= 1'b0;
			s_q.aw_addr   <= '0;
			s_q.w_have    <= 1'b0;
			s_q.wdata     <= 8'h00;
			s_q.wstb      <= 1'b0;
			s_q.awready   <= 1'b0;
			s_q.wready    <= 1'b0;
			s_q.bvalid    <= 1'b0;
			s_q.bresp     <= RESP_OKAY;
			s_q.arready   <= 1'b0;
			s_q.rvalid    <= 1'b0;
			s_q.rresp     <= RESP_OKAY;
			s_q.rdata     <= 8'h00;
			s_q.cpu_reset <= 1'b1;
			s_q.mosc_off  <= 1'b1;
			s_q.sosc_off  <= 1'b0;
			s_q.bgap_on   <= 1'b1;
			s_q.throttle  <= 1'b0;
			s_q.irq       <= 1'b0;
			s_q.osc_ticks <= 2'h0;
			s_q.hlp_ticks <= 10'h000;
		end
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from the record
	assign s_axi_awready           = s_q.awready;
	assign s_axi_wready            = s_q.wready;
	assign s_axi_bvalid            = s_q.bvalid;
	assign s_axi_bresp             = s_q.bresp;
	assign s_axi_arready           = s_q.arready;
	assign s_axi_rvalid            = s_q.rvalid;
	assign s_axi_rresp             = s_q.rresp;
	assign s_axi_rdata             = {24'h000000, s_q.rdata};
	assign internal_reset          = s_q.cpu_reset;
	assign main_osc_power_down     = s_q.mosc_off;
	assign slow_osc_power_down     = s_q.sosc_off;
	assign bandgap_power_on        = s_q.bgap_on;
	assign throttle_speed_reset    = s_q.throttle;
	assign low_voltage_irq         = s_q.irq;
	assign supply_trip_level       = s_q.vmctrl[TRIP_LSB+1:TRIP_LSB];
	assign throttle_on_low_voltage = s_q.vmctrl[THROTTLE_B];
	assign low_voltage_threshold   = s_q.vmctrl[THRESH_LSB+2:THRESH_LSB];
	assign power_on_flag           = s_q.pon;
	assign ram_init_limit          = s_q.ramlim;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking rvms_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_hold_while_source: assert property (
		sup_src |=> internal_reset)
		else $error("reset released while a source is active");

	a_main_osc_off: assert property (
		sup_src
		|=> main_osc_power_down ##0 (s_q.state == ST_HOLD))
		else $error("main oscillator running during supply reset");

	a_release_count: assert property (
		(s_q.state == ST_SYNC) |-> (s_q.hlp_ticks == rvms_rel_ticks(s_q.kind)))
		else $error("release count differs from the source count");

	a_release_sync: assert property (
		$fell(internal_reset) |-> $past(s_q.state == ST_SYNC)
		##0 $past(s_q.state == ST_COUNT, 2))
		else $error("release not preceded by count and sync");

	a_wdr_flags: assert property (
		((s_q.state == ST_WDOG) && !sup_src)
		|=> !power_on_flag && s_q.wdrf)
		else $error("watchdog reset flags wrong");

	a_slow_osc_only: assert property (
		slow_osc_power_down |-> $past(imprecise_supply_reset))
		else $error("slow oscillator stopped by another source");

	a_osc_before_rel: assert property (
		$fell(internal_reset) |-> (s_q.osc_ticks != 2'h0))
		else $error("main oscillator not on a tick before release");

	a_ctrl_cleared: assert property (
		(s_q.state == ST_HOLD) |-> (s_q.vmctrl == VMCTRL_RST))
		else $error("monitor control kept during reset");

	a_throttle_path: assert property (
		throttle_speed_reset
		== (throttle_on_low_voltage && $past(low_voltage_detect)))
		else $error("throttle differs from enable and detect");

	a_irq_follows: assert property (
		low_voltage_detect [*2] |-> low_voltage_irq)
		else $error("interrupt missing on low supply");

	a_pon_no_sw_set: assert property (
		$rose(power_on_flag) |-> $past(s_d.state != ST_RUN)
		or $past(s_q.state != ST_RUN))
		else $error("power flag set outside a reset");

endmodule

// >>> verification/rvms_core_model.sv
// Processor core model that receives the released reset.
// Assumes the slow tick arrives as a level sampled on aclk.
`timescale 1ns/1ns
module rvms_core_model
(
	input  wire logic aclk,
	input  wire logic internal_reset,
	input  wire logic main_osc_power_down,
	input  wire logic slow_tick_clock,
	output int        release_count,
	output logic      osc_short
);
	logic tick_q;
	logic rst_q;
	int   on_ticks;

	initial
	begin
		release_count = 0;
		osc_short = 1'b0;
		on_ticks = 0;
	end

	// Count ticks with the main oscillator up; unknown counts as off
	always @(posedge aclk)
	begin
		tick_q <= slow_tick_clock;
		rst_q <= internal_reset;
		if (main_osc_power_down !== 1'b0)
			on_ticks <= 0;
		else if (slow_tick_clock && !tick_q)
			on_ticks <= on_ticks + 1;
		if (rst_q && internal_reset === 1'b0)
		begin
			release_count <= release_count + 1;
			if (on_ticks < 1)
				osc_short <= 1'b1;
		end
	end
endmodule

// >>> verification/rvms_top_test.sv
// Self-checking bench of the reset sequencer with a register model.
// Assumes the slow tick may run fast; counts are taken in tick edges.
`timescale 1ns/1ns
module rvms_top_test;
	import rvms_pkg::*;
	logic aclk, aresetn, imprecise_supply_reset, precise_supply_reset;
	logic external_reset_pin, watchdog_reset_event, low_voltage_detect;
	logic slow_tick_clock, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, internal_reset;
	logic main_osc_power_down, slow_osc_power_down, bandgap_power_on;
	logic throttle_speed_reset, low_voltage_irq, throttle_on_low_voltage;
	logic power_on_flag, ram_init_limit, osc_short, tick_q;
	logic m_pon, m_wdf, m_ram;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, supply_trip_level, tdiv;
	logic [2:0]        low_voltage_threshold;
	logic [5:0]        m_ctrl;
	logic [7:0]        m_trim;
	int miscompares, samples_checked, tick_cnt, release_count;
	int ord[5] = '{3, 1, 2, 4, 0};
	int lo[5] = '{REL_IMPRECISE_SUPPLY_RESET, REL_PRECISE_SUPPLY_RESET + 1, REL_EXTERNAL_RESET_PIN, REL_WDR, REL_PRECISE_SUPPLY_RESET + 1};

	rvms_top u_rvms_top
	(
		.aclk,
		.aresetn,
		.imprecise_supply_reset,
		.precise_supply_reset,
		.external_reset_pin,
		.watchdog_reset_event,
		.low_voltage_detect,
		.slow_tick_clock,
		.s_axi_awvalid,
		.s_axi_awready,
		.s_axi_awaddr,
		.s_axi_wvalid,
		.s_axi_wready,
		.s_axi_wdata,
		.s_axi_wstrb,
		.s_axi_bvalid,
		.s_axi_bready,
		.s_axi_bresp,
		.s_axi_arvalid,
		.s_axi_arready,
		.s_axi_araddr,
		.s_axi_rvalid,
		.s_axi_rready,
		.s_axi_rdata,
		.s_axi_rresp,
		.internal_reset,
		.main_osc_power_down,
		.slow_osc_power_down,
		.bandgap_power_on,
		.throttle_speed_reset,
		.low_voltage_irq,
		.supply_trip_level,
		.throttle_on_low_voltage,
		.low_voltage_threshold,
		.power_on_flag,
		.ram_init_limit
	);

	rvms_core_model u_rvms_core_model
	(
		.aclk,
		.internal_reset,
		.main_osc_power_down,
		.slow_tick_clock,
		.release_count,
		.osc_short
	);

	////////////////////////////////////////////////////////////////////////
	// Clock, slow tick and watchdog
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Tick period of 8 cycles keeps 512-tick counts short; stops when off
	always @(posedge aclk)
	begin
		tdiv <= tdiv + 2'h1;
		tick_q <= slow_tick_clock;
		if (tdiv == 2'h3 && slow_osc_power_down === 1'b0)
			slow_tick_clock <= ~slow_tick_clock;
		if (slow_tick_clock && !tick_q)
			tick_cnt <= tick_cnt + 1;
	end

	// Cuts a hang short
	initial
	begin
		#200000;
		miscompares++;
		wrap_up;
	end

	////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic wrap_up;
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk_val(input string n, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %s expected %0h seen %0h", n, e, g);
		end
	endtask

	task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		// Each channel is released at its own handshake edge
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Bus write that also updates the register model
	task automatic reg_wr(input logic [7:0] idx, input logic [31:0] d);
		logic [1:0] r;
		axi_wr({idx, 2'h0}, d, r);
		chk_val("write_resp", 32'(RESP_OKAY), 32'(r));
		if (idx == IDX_VMCTRL)
			m_ctrl = d[5:0];
		if (idx == IDX_TRIM)
			m_trim = d[7:0];
		if (idx == IDX_STATUS)
		begin
			m_pon = m_pon & d[PON_B];
			m_wdf = m_wdf & d[WDRF_B];
			m_ram = d[RAMLIM_B];
		end
	endtask

	task automatic rd_chk(input string n, input logic [7:0] idx,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd({idx, 2'h0}, d, r);
		chk_val(n, e, d);
		chk_val("read_resp", 32'(RESP_OKAY), 32'(r));
	endtask

	task automatic check_regs;
		rd_chk("control", IDX_VMCTRL, 32'(m_ctrl));
		rd_chk("trim", IDX_TRIM, 32'(m_trim));
		rd_chk("status", IDX_STATUS,
			32'({m_wdf, m_pon, 3'h0, m_ram}));
		rd_chk("comparator", IDX_VMCMP,
			32'({low_voltage_detect, 1'b0}));
		chk_val("trip", 32'(m_ctrl[5:4]),
			32'(supply_trip_level));
		chk_val("tb_en", 32'(m_ctrl[3]),
			32'(throttle_on_low_voltage));
		chk_val("thresh", 32'(m_ctrl[2:0]),
			32'(low_voltage_threshold));
		chk_val("pon", 32'(m_pon), 32'(power_on_flag));
		chk_val("ram_lim", 32'(m_ram), 32'(ram_init_limit));
	endtask

	// Ticks from source end to release must sit in [n, n+2]
	task automatic wait_rel(input int n);
		int t0;
		t0 = tick_cnt;
		while (internal_reset !== 1'b0)
		begin
			// Mid-count of a long release: oscillator still held off
			if (n >= 8 && tick_cnt - t0 == n / 2)
				chk_val("lp_off", 32'h1,
					32'(main_osc_power_down));
			@(posedge aclk);
		end
		chk_val("release_ticks", 32'h1,
			32'((tick_cnt - t0 >= n) && (tick_cnt - t0 <= n + 2)));
		@(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		{aresetn, imprecise_supply_reset, precise_supply_reset} = 3'h0;
		{external_reset_pin, watchdog_reset_event, low_voltage_detect} = 3'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, slow_tick_clock} = 3'h0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		tdiv = 2'h0;
		tick_cnt = 0;
		miscompares = 0;
		samples_checked = 0;
		{m_ctrl, m_trim, m_wdf, m_ram, m_pon} =
			{VMCTRL_RST[5:0], TRIM_RST, 3'h1};
		void'($urandom(66573));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		wait_rel(REL_IMPRECISE_SUPPLY_RESET);
		check_regs;
		// Random control codes, reserved trip code and bits kept out
		for (int j = 0; j < 4; j++)
		begin
			d = $urandom;
			d[3] = d[3] | (j == 0);
			d[5] = d[5] & ~d[4];
			reg_wr(IDX_VMCTRL, d & 32'h3F);
			reg_wr(IDX_TRIM, $urandom);
			low_voltage_detect <= (j == 0) || ($urandom_range(1) == 1);
			repeat (3) @(posedge aclk);
			chk_val("throttle", 32'(m_ctrl[3] & low_voltage_detect),
				32'(throttle_speed_reset));
			chk_val("irq", 32'(low_voltage_detect),
				32'(low_voltage_irq));
			check_regs;
		end
		// Read-only comparator, unmapped place, status clear-only flags
		reg_wr(IDX_VMCMP, 32'hFF);
		axi_wr(10'h3FC, 32'hFF, r);
		chk_val("bad_wr_resp", 32'(RESP_SLVERR), 32'(r));
		axi_rd(10'h3FC, d, r);
		chk_val("bad_rd_resp", 32'(RESP_SLVERR), 32'(r));
		chk_val("bad_rd_data", 32'h0, d);
		reg_wr(IDX_STATUS, 32'h01);
		reg_wr(IDX_STATUS, 32'h31);
		check_regs;
		// Every source in turn; kind 4 overlaps pin and precise supply
		for (int i = 0; i < 5; i++)
		begin
			k = ord[i];
			d = $urandom;
			d[5] = d[5] & ~d[4];
			reg_wr(IDX_VMCTRL, d & 32'h3F);
			reg_wr(IDX_TRIM, (k == 4) ? 32'h0 : $urandom);
			reg_wr(IDX_STATUS, 32'h01);
			@(posedge aclk);
			imprecise_supply_reset <= (k == 0);
			precise_supply_reset <= (k == 1 || k == 4);
			external_reset_pin <= (k == 2 || k == 4);
			watchdog_reset_event <= (k == 3);
			@(posedge aclk);
			watchdog_reset_event <= 1'b0;
			repeat (3) @(posedge aclk);
			chk_val("in_reset", 32'h1, 32'(internal_reset));
			chk_val("main_off", 32'(k != 3),
				32'(main_osc_power_down));
			chk_val("slow_off", 32'(k == 0),
				32'(slow_osc_power_down));
			chk_val("bandgap", 32'h1, 32'(bandgap_power_on));
			imprecise_supply_reset <= 1'b0;
			external_reset_pin <= 1'b0;
			if (k == 4)
				repeat (5) @(posedge aclk);
			precise_supply_reset <= 1'b0;
			wait_rel(lo[k]);
			m_ctrl = VMCTRL_RST[5:0];
			if (k != 1)
				m_trim = TRIM_RST;
			m_pon = (k != 3);
			m_wdf = (k == 3);
			m_ram = m_ram & (k == 3);
			check_regs;
		end
		chk_val("releases", 32'h6, 32'(release_count));
		chk_val("osc_short", 32'h0, 32'(osc_short));
		wrap_up;
	end
endmodule
